// File: design/rss_pkg.sv
`default_nettype none
package rss_pkg;
  // Register byte offsets
  localparam logic [4:0] CMD_OFS = 5'h00; // Command code and argument
  localparam logic [4:0] STAT_OFS = 5'h04; // Busy, answer valid, route, short bits
  localparam logic [4:0] SETTLE_OFS = 5'h08; // Settling time in ms
  localparam logic [4:0] RESP0_OFS = 5'h0c; // Answer characters 0..3
  localparam logic [4:0] RESP1_OFS = 5'h10; // Answer characters 4..7
  localparam logic [4:0] RESP2_OFS = 5'h14; // Answer characters 8..9
  localparam logic [4:0] RLEN_OFS = 5'h18; // Answer length in characters
  // Command codes in the low byte of the command register
  localparam logic [7:0] OP_SCAN = 8'h01; // Scan all channels for shorts
  localparam logic [7:0] OP_EXT_SET = 8'h02; // Set routing relay, argument in bits 15:8
  localparam logic [7:0] OP_EXT_QUERY = 8'h03; // Report routing relay
  // Status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_EXT_BIT = 2;
  localparam int STAT_SHORT_LSB = 8;
  // Answer characters
  localparam logic [7:0] CH_OPEN = 8'h3c; // '<'
  localparam logic [7:0] CH_CLOSE = 8'h3e; // '>'
  localparam logic [7:0] CH_ZERO = 8'h30; // '0'
  localparam logic [7:0] CH_ONE = 8'h31; // '1'
  localparam logic [7:0] CH_O = 8'h4f; // 'O'
  localparam logic [7:0] CH_K = 8'h4b; // 'K'
  localparam int RESP_CHARS = 10; // Longest answer, the framed scan result
  // Reset values
  localparam logic [7:0] SETTLE_RESET_MS = 8'h05;
  localparam logic [7:0] SETTLE_MAX_MS = 8'h09; // Keeps eight channels inside the scan budget
  localparam logic EXT_RESET = 1'b1; // Lines idle high after init
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 500; // Least half period of the serial clock
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int CLEAR_PULSE_NS = 1000; // Least width of the open-all pulse
  localparam int CLEAR_CYC = (CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_LIMIT_MS = 80; // Whole scan budget
  // Scan sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BIT_HI = 3'b001,
    ST_BIT_LO = 3'b010,
    ST_SETTLE = 3'b011,
    ST_SAMPLE = 3'b100,
    ST_CLEAR = 3'b101,
    ST_DONE = 3'b110
  } rss_state_t;
endpackage : rss_pkg
`default_nettype wire

// File: design/rss_scan_ctrl.sv
// How it works
// - Scan channels 0..7, store bit 7-index, clear
// - Scan answer: eight ASCII bits in angle brackets
// - Route query answers framed '1' or '0'
// - Route mode switches channels to external instrument
// - Short flag high means low impedance short
// - Full scan finishes within 80 ms
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rss_scan_ctrl #(
  parameter int CYC_PER_MS = rss_pkg::CYC_PER_MS, // Shorten in simulation
  parameter int SCAN_LIMIT_CYC = rss_pkg::SCAN_LIMIT_MS * rss_pkg::CYC_PER_MS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic sclk,
  output logic dout,
  output logic relay_driver_select_n,
  output logic relay_open_all_line,
  output logic relay_close_all_line,
  output logic external_route_line,
  input wire logic short_detect_input
);

  // Turns a stored short bit into its answer character
  function automatic logic [7:0] asciiBit(input logic b);
    asciiBit = b ? rss_pkg::CH_ONE : rss_pkg::CH_ZERO;
  endfunction : asciiBit

  // Result position of a channel
  function automatic logic [2:0] bitPos(input logic [2:0] ch);
    bitPos = 3'h7 - ch;
  endfunction : bitPos

  rss_pkg::rss_state_t stateReg, stateNext; // Scan sequencer
  logic [2:0] chanReg, chanNext; // Channel being scanned
  logic [2:0] bitReg, bitNext; // Serial bit being shifted
  logic [23:0] timerReg, timerNext; // Down counter for every wait
  logic [7:0] shortReg; // Stored short bits, channel 0 in bit 7
  logic extReg; // Routing relay state
  logic [7:0] settleReg; // Settling time in ms
  logic [15:0] cmdReg; // Last command written
  logic busyReg; // Scan in progress
  logic validReg; // Answer ready to read
  logic [3:0] lenReg; // Answer length
  logic [7:0] respReg [0:rss_pkg::RESP_CHARS-1]; // Answer characters
  logic ackReg; // Second cycle of a bus access
  logic [31:0] rdReg; // Registered read data
  logic sclkReg, doutReg, selNReg, openNReg; // Registered pins
  logic [20:0] scanCycles; // Scan length, only watched by a check

  // Bus access decode: every access takes one wait state
  wire logic access = avs_read | avs_write;
  wire logic wrAck = avs_write & ackReg;
  wire logic lowLanes = &avs_byteenable[1:0];
  wire logic cmdAccept = wrAck & (avs_address == rss_pkg::CMD_OFS) & lowLanes & ~busyReg;
  wire logic settleWr = wrAck & (avs_address == rss_pkg::SETTLE_OFS) & avs_byteenable[0];
  wire logic [7:0] opWr = avs_writedata[7:0];
  wire logic [7:0] argWr = avs_writedata[15:8];
  wire logic argOk = (argWr == rss_pkg::CH_ZERO) | (argWr == rss_pkg::CH_ONE);
  wire logic isScan = opWr == rss_pkg::OP_SCAN;
  wire logic isExtSet = opWr == rss_pkg::OP_EXT_SET;
  wire logic isExtQuery = opWr == rss_pkg::OP_EXT_QUERY;
  wire logic timerDone = timerReg == 24'h000000;

  // Select pattern of the channel about to be shifted, only its bit low; built from the next channel
  // so a new frame never starts with the first bit of the channel before it
  wire logic [7:0] patternNext = ~(8'h01 << chanNext);
  wire logic frameNext = (stateNext == rss_pkg::ST_BIT_HI) | (stateNext == rss_pkg::ST_BIT_LO); // Select low
  wire logic [23:0] settleCyc = 24'(settleReg) * 24'(CYC_PER_MS);
  wire logic [31:0] statusWord = {16'h0000, shortReg, 5'h00, extReg, validReg, busyReg};

  // Read data selection; unmapped offsets read zero
  wire logic [31:0] rdMux =
    (avs_address == rss_pkg::CMD_OFS) ? {16'h0000, cmdReg} :
    (avs_address == rss_pkg::STAT_OFS) ? statusWord :
    (avs_address == rss_pkg::SETTLE_OFS) ? {24'h000000, settleReg} :
    (avs_address == rss_pkg::RESP0_OFS) ? {respReg[3], respReg[2], respReg[1], respReg[0]} :
    (avs_address == rss_pkg::RESP1_OFS) ? {respReg[7], respReg[6], respReg[5], respReg[4]} :
    (avs_address == rss_pkg::RESP2_OFS) ? {16'h0000, respReg[9], respReg[8]} :
    (avs_address == rss_pkg::RLEN_OFS) ? {28'h0000000, lenReg} : 32'h00000000;

  assign avs_waitrequest = access & ~ackReg;
  assign avs_readdata = rdReg;
  assign sclk = sclkReg;
  assign dout = doutReg;
  assign relay_driver_select_n = selNReg;
  assign relay_open_all_line = openNReg;
  assign relay_close_all_line = 1'b1; // Close-all is never used by this block
  assign external_route_line = extReg;

  // Bus handshake and read data capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ackReg <= 1'b0;
      rdReg <= 32'h00000000;
    end else begin
      ackReg <= access & ~ackReg;
      if (avs_read & ~ackReg) begin
        rdReg <= rdMux;
      end
    end
  end

  // Scan sequencer next state
  always_comb begin
    stateNext = stateReg;
    chanNext = chanReg;
    bitNext = bitReg;
    timerNext = timerDone ? timerReg : timerReg - 24'h000001;
    unique case (stateReg)
      rss_pkg::ST_IDLE: begin
        if (cmdAccept & isScan) begin
          stateNext = rss_pkg::ST_BIT_HI;
          chanNext = 3'h0;
          bitNext = 3'h7;
          timerNext = 24'(rss_pkg::SCLK_HALF_CYC - 1);
        end
      end
      rss_pkg::ST_BIT_HI: begin
        // Clock high with the bit held on the data line
        if (timerDone) begin
          stateNext = rss_pkg::ST_BIT_LO;
          timerNext = 24'(rss_pkg::SCLK_HALF_CYC - 1);
        end
      end
      rss_pkg::ST_BIT_LO: begin
        if (timerDone & (bitReg == 3'h0)) begin
          stateNext = rss_pkg::ST_SETTLE;
          timerNext = (settleCyc == 24'h000000) ? 24'h000000 : settleCyc - 24'h000001;
        end else if (timerDone) begin
          stateNext = rss_pkg::ST_BIT_HI;
          bitNext = bitReg - 3'h1;
          timerNext = 24'(rss_pkg::SCLK_HALF_CYC - 1);
        end
      end
      rss_pkg::ST_SETTLE: begin
        // Contacts bounce; sampling early would report a false open
        if (timerDone) begin
          stateNext = rss_pkg::ST_SAMPLE;
        end
      end
      rss_pkg::ST_SAMPLE: begin
        if (chanReg == 3'h7) begin
          stateNext = rss_pkg::ST_CLEAR;
          timerNext = 24'(rss_pkg::CLEAR_CYC - 1);
        end else begin
          stateNext = rss_pkg::ST_BIT_HI;
          chanNext = chanReg + 3'h1;
          bitNext = 3'h7;
          timerNext = 24'(rss_pkg::SCLK_HALF_CYC - 1);
        end
      end
      rss_pkg::ST_CLEAR: begin
        if (timerDone) begin
          stateNext = rss_pkg::ST_DONE;
        end
      end
      rss_pkg::ST_DONE: begin
        stateNext = rss_pkg::ST_IDLE;
      end
      default: begin
        stateNext = rss_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and pins; pins follow the next state so they never glitch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateReg <= rss_pkg::ST_IDLE;
      chanReg <= 3'h0;
      bitReg <= 3'h7;
      timerReg <= 24'h000000;
      sclkReg <= 1'b1;
      doutReg <= 1'b1;
      selNReg <= 1'b1;
      openNReg <= 1'b1;
    end else begin
      stateReg <= stateNext;
      chanReg <= chanNext;
      bitReg <= bitNext;
      timerReg <= timerNext;
      sclkReg <= stateNext != rss_pkg::ST_BIT_LO;
      selNReg <= ~frameNext;
      openNReg <= stateNext != rss_pkg::ST_CLEAR;
      // Data changes together with the rising clock edge; half a period of hold follows
      doutReg <= frameNext ? patternNext[bitNext] : 1'b1;
    end
  end

  // Short bits: a high flag means a short on the routed channel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shortReg <= 8'h00;
    end else if (cmdAccept & isScan) begin
      shortReg <= 8'h00;
    end else if (stateReg == rss_pkg::ST_SAMPLE) begin
      shortReg[bitPos(chanReg)] <= short_detect_input;
    end
  end

  // Settling time, command, routing relay and busy flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settleReg <= rss_pkg::SETTLE_RESET_MS;
      cmdReg <= 16'h0000;
      extReg <= rss_pkg::EXT_RESET;
      busyReg <= 1'b0;
    end else begin
      if (settleWr) begin
        // Saturated so a scan cannot overrun its time budget
        settleReg <= (avs_writedata[7:0] > rss_pkg::SETTLE_MAX_MS) ?
                     rss_pkg::SETTLE_MAX_MS : avs_writedata[7:0];
      end
      if (cmdAccept) begin
        cmdReg <= avs_writedata[15:0];
      end
      if (cmdAccept & isExtSet & argOk) begin
        extReg <= argWr[0];
      end
      if (cmdAccept & isScan) begin
        busyReg <= 1'b1;
      end else if (stateReg == rss_pkg::ST_DONE) begin
        busyReg <= 1'b0;
      end
    end
  end

  // Answer buffer; a command written while busy is ignored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      validReg <= 1'b0;
      lenReg <= 4'h0;
      for (int i = 0; i < rss_pkg::RESP_CHARS; i++) begin
        respReg[i] <= 8'h00;
      end
    end else if (stateReg == rss_pkg::ST_DONE) begin
      validReg <= 1'b1;
      lenReg <= 4'ha;
      respReg[0] <= rss_pkg::CH_OPEN;
      for (int i = 0; i < 8; i++) begin
        respReg[i + 1] <= asciiBit(shortReg[7 - i]);
      end
      respReg[9] <= rss_pkg::CH_CLOSE;
    end else if (cmdAccept & isScan) begin
      validReg <= 1'b0;
    end else if (cmdAccept & isExtQuery) begin
      validReg <= 1'b1;
      lenReg <= 4'h3;
      respReg[0] <= rss_pkg::CH_OPEN;
      respReg[1] <= asciiBit(extReg);
      respReg[2] <= rss_pkg::CH_CLOSE;
    end else if (cmdAccept & isExtSet) begin
      validReg <= 1'b1;
      lenReg <= 4'h2;
      respReg[0] <= argOk ? rss_pkg::CH_O : rss_pkg::CH_CLOSE;
      respReg[1] <= argOk ? rss_pkg::CH_K : rss_pkg::CH_CLOSE;
    end else if (cmdAccept) begin
      validReg <= 1'b1;
      lenReg <= 4'h2;
      respReg[0] <= rss_pkg::CH_CLOSE;
      respReg[1] <= rss_pkg::CH_OPEN;
    end
  end

  // Scan length counter for the budget check
  always_ff @(posedge sys_clk) begin
    if (rst | ~busyReg) begin
      scanCycles <= 21'h000000;
    end else if (scanCycles != 21'h1fffff) begin
      scanCycles <= scanCycles + 21'h000001;
    end
  end

  chk_sample_bit_pos: assert property (@(posedge sys_clk) disable iff (rst)
    (stateReg == rss_pkg::ST_SAMPLE) |=> shortReg[bitPos($past(chanReg))] == $past(short_detect_input))
    else $error("short bit stored at wrong position");
  chk_short_level: assert property (@(posedge sys_clk) disable iff (rst)
    (stateReg == rss_pkg::ST_SAMPLE) && short_detect_input |=> shortReg != 8'h00)
    else $error("high short flag not recorded");
  chk_clear_relays: assert property (@(posedge sys_clk) disable iff (rst)
    (stateReg == rss_pkg::ST_SAMPLE) && (chanReg == 3'h7) |=> !relay_open_all_line [*2])
    else $error("relays not cleared after last channel");
  chk_scan_frame: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busyReg) |-> lenReg == 4'ha && respReg[0] == rss_pkg::CH_OPEN && respReg[9] == rss_pkg::CH_CLOSE)
    else $error("scan answer not framed");
  chk_scan_chars: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busyReg) |-> respReg[1] == asciiBit(shortReg[7]) && respReg[8] == asciiBit(shortReg[0]))
    else $error("scan answer characters wrong");
  chk_ext_query: assert property (@(posedge sys_clk) disable iff (rst)
    cmdAccept && isExtQuery |=> respReg[1] == asciiBit(external_route_line) && lenReg == 4'h3 && validReg)
    else $error("route query answer wrong");
  chk_ext_route: assert property (@(posedge sys_clk) disable iff (rst)
    cmdAccept && isExtSet && argWr == rss_pkg::CH_ONE |=> external_route_line [*1] ##1 external_route_line)
    else $error("route line not switched");
  chk_scan_budget: assert property (@(posedge sys_clk) disable iff (rst)
    busyReg |-> 32'(scanCycles) < 32'(SCAN_LIMIT_CYC))
    else $error("scan exceeded its time budget");

endmodule : rss_scan_ctrl
`default_nettype wire

// File: tb/rss_relay_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the serial relay driver and the short sensor behind it
module rss_relay_model #(
  parameter int SETTLE_CYC = 80 // Contacts and sensor need this long after a latch
) (
  input wire logic sysClk,
  input wire logic sclk,
  input wire logic dout,
  input wire logic selectN,
  input wire logic openAllN,
  input wire logic [7:0] shortMask, // Channels wired to a short
  output logic shortFlag,
  output logic [7:0] relayState, // One means relay closed
  output logic [7:0] selCount, // Latches seen
  output logic [7:0] errCount // Malformed or out-of-order frames
);
  logic [7:0] shiftReg; // Bits gathered in the current frame
  int bitCnt; // Bits in the current frame
  int latchSeq; // Bumps at every latch
  int seenSeq; // Last latch the sensor has seen
  int settleCnt; // Cycles since the last latch
  logic hit; // A closed relay sits on a short
  initial begin
    shiftReg = 8'h00;
    bitCnt = 0;
    latchSeq = 0;
    relayState = 8'h00;
    selCount = 8'h00;
    errCount = 8'h00;
  end
  // Data stands over the high phase, so take it as the clock falls
  always @(negedge sclk) begin
    if (!selectN) begin
      shiftReg = {shiftReg[6:0], dout};
      bitCnt++;
    end
  end
  // Deselect latches: eight bits, one active-low bit, channels in turn
  always @(posedge selectN) begin
    if (bitCnt > 0) begin
      if (bitCnt != 8 || ~shiftReg != (8'h01 << selCount[2:0])) errCount++;
      relayState = ~shiftReg;
      selCount++;
      latchSeq++;
      bitCnt = 0;
    end
  end
  // Open-all pulse drops every relay
  always @(negedge openAllN) relayState = 8'h00;
  // Sensor reads wrong until settled, so an early sample is caught
  always @(posedge sysClk) begin
    if (seenSeq != latchSeq) begin
      seenSeq <= latchSeq;
      settleCnt <= 0;
    end else if (settleCnt < SETTLE_CYC) begin
      settleCnt <= settleCnt + 1;
    end
  end
  assign hit = |(relayState & shortMask);
  assign shortFlag = (settleCnt >= SETTLE_CYC) ? hit : !hit;
endmodule : rss_relay_model
`default_nettype wire

// File: tb/rss_scan_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rss_scan_ctrl_tb;
  localparam int CPM = 20; // Shortened millisecond
  localparam int LIMIT_CYC = 4000; // Serial shifting does not shrink with the millisecond
  localparam logic [7:0] MASK = 8'h05; // Channels 0 and 2 shorted
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0] avsByteenable = 4'hf;
  logic [31:0] avsReaddata;
  logic avsWaitrequest, sclk, dout, selN, openN, closeN, extLine, shortFlag;
  logic [7:0] shortMask = 8'h00;
  logic [7:0] relayState, selCount, errCount;
  int mismatches = 0;
  int samplesChecked = 0;
  int cycleCnt = 0;
  rss_scan_ctrl #(.CYC_PER_MS(CPM), .SCAN_LIMIT_CYC(LIMIT_CYC)) i_rss_scan_ctrl (.sys_clk(sysClk), .rst(rst),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .sclk(sclk), .dout(dout), .relay_driver_select_n(selN), .relay_open_all_line(openN),
    .relay_close_all_line(closeN), .external_route_line(extLine), .short_detect_input(shortFlag));
  rss_relay_model #(.SETTLE_CYC(80)) i_rss_relay_model (.sysClk(sysClk), .sclk(sclk), .dout(dout),
    .selectN(selN), .openAllN(openN), .shortMask(shortMask), .shortFlag(shortFlag),
    .relayState(relayState), .selCount(selCount), .errCount(errCount));
  // Clock and elapsed-cycle count
  always #25 sysClk = ~sysClk;
  always @(posedge sysClk) cycleCnt <= cycleCnt + 1;
  // Verdict and end of run
  task test_done();
    if (mismatches == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : checkVal
  // Bus cycles: hold until waitrequest is seen low, then release
  task automatic busWrite(input logic [4:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    @(posedge sysClk);
    while (avsWaitrequest !== 1'b0) @(posedge sysClk);
    avsWrite <= 1'b0;
    @(posedge sysClk);
  endtask : busWrite
  task automatic busRead(input logic [4:0] a, output logic [31:0] d);
    avsAddress <= a;
    avsRead <= 1'b1;
    @(posedge sysClk);
    while (avsWaitrequest !== 1'b0) @(posedge sysClk);
    d = avsReaddata;
    avsRead <= 1'b0;
    @(posedge sysClk);
  endtask : busRead
  // Poll busy, bounded
  task automatic waitIdle();
    logic [31:0] w;
    int n;
    w = 32'h1;
    n = 0;
    while (w[rss_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 2000) begin
      busRead(rss_pkg::STAT_OFS, w);
      n++;
    end
    if (n >= 2000) checkVal("busy", 32'h0, 32'h1);
  endtask : waitIdle
  // Answer text: length, then characters, first in byte 0
  task automatic checkAnswer(input string s);
    logic [31:0] w;
    busRead(rss_pkg::RLEN_OFS, w);
    checkVal("answer length", 32'(s.len()), w);
    for (int i = 0; i < s.len(); i++) begin
      if (i % 4 == 0) busRead(rss_pkg::RESP0_OFS + 5'(i), w);
      checkVal("answer char", {24'h0, s[i]}, {24'h0, w[8 * (i % 4) +: 8]});
    end
  endtask : checkAnswer
  // Idle lines, reset values, settle clamp, unmapped read
  task automatic testReset();
    logic [31:0] w;
    checkVal("idle lines", 32'h3f, {26'h0, sclk, dout, selN, openN, closeN, extLine});
    busRead(rss_pkg::STAT_OFS, w);
    checkVal("route status", 32'h1, {31'h0, w[rss_pkg::STAT_EXT_BIT]});
    busRead(rss_pkg::SETTLE_OFS, w);
    checkVal("settle reset", {24'h0, rss_pkg::SETTLE_RESET_MS}, w);
    busWrite(rss_pkg::SETTLE_OFS, 32'h0000000f);
    busRead(rss_pkg::SETTLE_OFS, w);
    checkVal("settle clamp", {24'h0, rss_pkg::SETTLE_MAX_MS}, w);
    busWrite(rss_pkg::SETTLE_OFS, {24'h0, rss_pkg::SETTLE_RESET_MS});
    busRead(5'h1c, w);
    checkVal("unmapped read", 32'h0, w);
  endtask : testReset
  // Scan with two shorts; a route command sent while busy must be ignored
  task automatic testScan();
    logic [31:0] w;
    logic [7:0] expBits;
    int t0;
    shortMask <= MASK;
    for (int ch = 0; ch < 8; ch++) expBits[7 - ch] = MASK[ch];
    t0 = cycleCnt;
    busWrite(rss_pkg::CMD_OFS, {24'h0, rss_pkg::OP_SCAN});
    busWrite(rss_pkg::CMD_OFS, {16'h0, 8'h30, rss_pkg::OP_EXT_SET});
    waitIdle();
    checkVal("scan time", 32'h1, {31'h0, (cycleCnt - t0) <= LIMIT_CYC});
    busRead(rss_pkg::STAT_OFS, w);
    checkVal("short bits", {24'h0, expBits}, {24'h0, w[15:8]});
    checkVal("answer valid", 32'h1, {31'h0, w[rss_pkg::STAT_VALID_BIT]});
    checkAnswer($sformatf("<%8b>", expBits));
    checkVal("selections", 32'h8, {24'h0, selCount});
    checkVal("frame errors", 32'h0, {24'h0, errCount});
    checkVal("relays cleared", 32'h0, {24'h0, relayState});
    checkVal("route kept", 32'h1, {31'h0, extLine});
    checkVal("lines idle", 32'h7, {29'h0, sclk, selN, openN});
  endtask : testScan
  // Route set and query, bad argument, bad opcode, partial write
  task automatic testRoute();
    logic [7:0] ops [6] = '{rss_pkg::OP_EXT_QUERY, rss_pkg::OP_EXT_SET, rss_pkg::OP_EXT_QUERY,
      rss_pkg::OP_EXT_SET, rss_pkg::OP_EXT_SET, 8'h07};
    logic [7:0] args [6] = '{8'h00, 8'h30, 8'h00, 8'h37, 8'h31, 8'h00};
    string ans [6] = '{"<1>", "OK", "<0>", ">>", "OK", "><"};
    logic lineExp [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    avsByteenable <= 4'h0;
    busWrite(rss_pkg::CMD_OFS, {16'h0, 8'h30, rss_pkg::OP_EXT_SET});
    avsByteenable <= 4'hf;
    waitIdle();
    checkVal("partial write", 32'h1, {31'h0, extLine});
    for (int i = 0; i < 6; i++) begin
      busWrite(rss_pkg::CMD_OFS, {16'h0, args[i], ops[i]});
      waitIdle();
      checkAnswer(ans[i]);
      checkVal("route line", {31'h0, lineExp[i]}, {31'h0, extLine});
    end
  endtask : testRoute
  // Main sequence
  initial begin
    repeat (2) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    testReset();
    testScan();
    testRoute();
    test_done();
  end
  // Watchdog, well past the expected run
  initial begin
    repeat (30000) @(posedge sysClk);
    mismatches++;
    test_done();
  end
endmodule : rss_scan_ctrl_tb
`default_nettype wire
